/* shared/debug_cmd_pkg.sv */
package debug_cmd_pkg;
  // Command codes
  localparam logic [7:0] CMD_REV    = 8'h00;
  localparam logic [7:0] CMD_STAT   = 8'h02;
  localparam logic [7:0] CMD_CTL_WR = 8'h04;
  localparam logic [7:0] CMD_CTL_RD = 8'h05;
  localparam logic [7:0] CMD_PC_WR  = 8'h06;
  localparam logic [7:0] CMD_PC_RD  = 8'h07;
  localparam logic [7:0] CMD_REG_WR = 8'h08;
  localparam logic [7:0] CMD_REG_RD = 8'h09;
  // Argument byte counts
  localparam logic [1:0] ARGS_CTL = 2'h1;
  localparam logic [1:0] ARGS_PC  = 2'h2;
  localparam logic [1:0] ARGS_REG = 2'h3;
  // Response byte counts
  localparam logic [8:0] ONE_BYTE   = 9'h001;
  localparam logic [8:0] TWO_BYTES  = 9'h002;
  localparam logic [8:0] BLOCK_MAX  = 9'h100;
  // Control register
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] CTL_WR_MASK = 8'he1;
  localparam int         HALT_BIT    = 7;
  localparam logic [7:0] FILL_BYTE   = 8'hff;
  // Serial framing
  localparam int         BAUD_SHIFT   = 3;
  localparam logic [3:0] BREAK_BITS   = 4'h9;
  localparam logic [3:0] FRAME_BITS   = 4'ha;
  localparam logic [2:0] DATA_LAST    = 3'h7;
  localparam logic [12:0] BREAK_CYCLES = 13'h1000;
endpackage

/* verilog/debug_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module debug_rx #(
  parameter int CW = 13
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // Synchronised line and control
  input  wire logic          line,
  input  wire logic          mute,
  input  wire logic          restart,
  // Received characters and errors
  output logic [7:0]         rx_data,
  output logic               rx_valid,
  output logic               rx_break,
  output logic               rx_frame_err,
  output logic [CW-4:0]      bit_len
);
  typedef enum logic [2:0] {
    RX_WAIT_HIGH, RX_AUTO_IDLE, RX_AUTO_LOW, RX_IDLE, RX_START, RX_DATA, RX_STOP
  } rx_state_t;
  rx_state_t     state, next_state;
  logic [CW-1:0] cnt, next_cnt, low_run, next_low_run;
  logic [CW-1:0] nine_bits, half, last;
  logic [CW-4:0] next_bit_len;
  logic [2:0]    idx, next_idx;
  logic [7:0]    next_rx_data;
  logic          next_valid, next_break, next_ferr, locked, next_locked;

  // Break needs nine and a half bit times, so a 00h character is no break
  assign nine_bits = CW'(bit_len) * CW'(debug_cmd_pkg::BREAK_BITS) + half;
  assign half      = CW'(bit_len >> 1);
  assign last      = CW'(bit_len) - CW'(1);

  always_comb begin
    next_state   = state;
    next_cnt     = cnt + CW'(1);
    next_low_run = line ? '0 : ((&low_run) ? low_run : low_run + CW'(1));
    next_bit_len = bit_len;
    next_idx     = idx;
    next_rx_data = rx_data;
    next_valid   = 1'b0;
    next_break   = 1'b0;
    next_ferr    = 1'b0;
    next_locked  = locked;
    case (state)
      RX_WAIT_HIGH: begin
        next_locked = 1'b0;
        if (line) next_state = RX_AUTO_IDLE;
      end
      RX_AUTO_IDLE: begin
        next_cnt = '0;
        if (!line) next_state = RX_AUTO_LOW;
      end
      RX_AUTO_LOW: begin
        if (&cnt) begin
          next_state = RX_WAIT_HIGH;
        end else if (line) begin
          // Low cycles counted, eight bit times long
          next_bit_len = (CW-3)'((cnt + CW'(1)) >> debug_cmd_pkg::BAUD_SHIFT);
          next_locked  = 1'b1;
          next_state   = RX_IDLE;
        end
      end
      RX_IDLE: begin
        next_cnt = '0;
        if (!line) next_state = RX_START;
      end
      RX_START: begin
        if (cnt == half) begin
          next_cnt   = '0;
          next_idx   = '0;
          next_state = line ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (cnt == last) begin
          next_cnt     = '0;
          next_rx_data = {line, rx_data[7:1]};
          next_idx     = idx + 3'h1;
          if (idx == debug_cmd_pkg::DATA_LAST) next_state = RX_STOP;
        end
      end
      RX_STOP: begin
        if (cnt == last) begin
          next_valid = line;
          next_ferr  = !line;
          next_state = line ? RX_IDLE : RX_WAIT_HIGH;
        end
      end
      default: next_state = RX_WAIT_HIGH;
    endcase
    if (locked && !line && low_run == nine_bits) begin
      next_break = 1'b1;
      next_state = RX_WAIT_HIGH;
    end
    if (mute && locked) begin
      next_state   = RX_IDLE;
      next_low_run = '0;
      next_break   = 1'b0;
    end
    if (restart) begin
      next_state  = RX_WAIT_HIGH;
      next_locked = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state        <= RX_WAIT_HIGH;
      cnt          <= '0;
      low_run      <= '0;
      bit_len      <= '0;
      idx          <= '0;
      rx_data      <= '0;
      rx_valid     <= 1'b0;
      rx_break     <= 1'b0;
      rx_frame_err <= 1'b0;
      locked       <= 1'b0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      low_run      <= next_low_run;
      bit_len      <= next_bit_len;
      idx          <= next_idx;
      rx_data      <= next_rx_data;
      rx_valid     <= next_valid;
      rx_break     <= next_break;
      rx_frame_err <= next_ferr;
      locked       <= next_locked;
    end
  end
endmodule // debug_rx
`default_nettype wire

/* verilog/debug_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module debug_tx #(
  parameter int CW = 13
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // Line sense and rate
  input  wire logic          line,
  input  wire logic [CW-4:0] bit_len,
  // Requests
  input  wire logic          tx_start,
  input  wire logic [7:0]    tx_byte,
  input  wire logic          brk_start,
  // Line drive and status
  output logic               drive_low,
  output logic               tx_busy,
  output logic               tx_done,
  output logic               tx_collision
);
  typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_BREAK} tx_state_t;
  tx_state_t     state, next_state;
  logic [CW-1:0] cnt, next_cnt, half, last;
  logic [9:0]    shreg, next_shreg;
  logic [3:0]    idx, next_idx;
  logic          next_drive, next_done, next_coll;

  assign half    = CW'(bit_len >> 1);
  assign last    = CW'(bit_len) - CW'(1);
  assign tx_busy = (state != TX_IDLE);

  always_comb begin
    next_state = state;
    next_cnt   = cnt + CW'(1);
    next_shreg = shreg;
    next_idx   = idx;
    next_drive = drive_low;
    next_done  = 1'b0;
    next_coll  = 1'b0;
    case (state)
      TX_IDLE: begin
        if (tx_start) begin
          next_shreg = {1'b1, tx_byte, 1'b0};
          next_state = TX_BITS;
          next_cnt   = '0;
          next_idx   = '0;
          next_drive = 1'b1;
        end
      end
      TX_BITS: begin
        if (cnt == half && shreg[0] && !line) begin
          next_coll  = 1'b1;
          next_state = TX_IDLE;
          next_drive = 1'b0;
        end else if (cnt == last) begin
          next_cnt   = '0;
          next_shreg = {1'b1, shreg[9:1]};
          next_idx   = idx + 4'h1;
          next_drive = !shreg[1];
          if (idx == debug_cmd_pkg::FRAME_BITS - 4'h1) begin
            next_state = TX_IDLE;
            next_done  = 1'b1;
            next_drive = 1'b0;
          end
        end
      end
      TX_BREAK: begin
        if (cnt == debug_cmd_pkg::BREAK_CYCLES - CW'(1)) begin
          next_state = TX_IDLE;
          next_done  = 1'b1;
          next_drive = 1'b0;
        end
      end
      default: next_state = TX_IDLE;
    endcase
    if (brk_start) begin
      next_state = TX_BREAK;
      next_cnt   = '0;
      next_drive = 1'b1;
      next_done  = 1'b0;
      next_coll  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state        <= TX_IDLE;
      cnt          <= '0;
      shreg        <= '1;
      idx          <= '0;
      drive_low    <= 1'b0;
      tx_done      <= 1'b0;
      tx_collision <= 1'b0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      shreg        <= next_shreg;
      idx          <= next_idx;
      drive_low    <= next_drive;
      tx_done      <= next_done;
      tx_collision <= next_coll;
    end
  end
endmodule // debug_tx
`default_nettype wire

/* verilog/debug_port_command_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module debug_port_command_decoder #(
  // Arbitrary revision value
  parameter logic [15:0] REVISION       = 16'h0101,
  parameter logic [11:0] FLASH_LO       = 12'hff8,
  parameter logic [11:0] FLASH_HI       = 12'hfff,
  parameter logic [11:0] FLASH_CTL_ADDR = 12'hff8,
  parameter logic [7:0]  MASS_ERASE     = 8'h94,
  parameter int          CNT_W          = 13
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Open-drain debug line
  input  wire logic        debug_serial_line_in,
  output logic             debug_serial_line_out,
  output logic             debug_serial_line_oe,
  // Option and status
  input  wire logic        readout_protect_option,
  input  wire logic [7:0]  debugger_status_reg,
  input  wire logic        halt_request,
  // Control register
  output logic [7:0]       debugger_control_reg,
  output logic             halt_mode_bit,
  // Program counter
  input  wire logic [15:0] program_counter,
  output logic [15:0]      pc_wdata,
  output logic             pc_write,
  // Register file
  output logic [11:0]      reg_addr,
  output logic [7:0]       reg_wdata,
  output logic             reg_write,
  output logic             reg_read,
  input  wire logic [7:0]  reg_rdata
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARG, ST_WDATA, ST_FETCH, ST_WAIT, ST_LOAD, ST_SEND, ST_BREAK
  } cmd_state_t;

  cmd_state_t     state, next_state;
  logic [7:0]     cmd, next_cmd;
  logic [15:0]    args, next_args;
  logic [23:0]    argv;
  logic [1:0]     arg_left, next_arg_left;
  logic [8:0]     left, next_left;
  logic [11:0]    addr, next_addr, next_reg_addr;
  logic [7:0]     ctl, next_ctl, next_reg_wdata, resp_byte;
  logic [15:0]    next_pc_wdata;
  logic           next_pc_write, next_reg_write, next_reg_read;
  logic           line_meta, line_sync, open_ok;
  logic           rx_valid, rx_break, rx_frame_err, rx_restart;
  logic [7:0]     rx_data;
  logic [CNT_W-4:0] bit_len;
  logic           tx_start, brk_start, tx_busy, tx_done, tx_collision, drive_low;
  logic [7:0]     tx_byte;

  // Writable control bits with halt bit held under protection
  function automatic logic [7:0] ctl_write(input logic [7:0] old_v,
                                           input logic [7:0] data,
                                           input logic       prot);
    logic [7:0] v;
    v = data & debug_cmd_pkg::CTL_WR_MASK;
    if (prot && old_v[debug_cmd_pkg::HALT_BIT]) begin
      v[debug_cmd_pkg::HALT_BIT] = 1'b1;
    end
    return v;
  endfunction

  // Write permission for one register byte
  function automatic logic wr_allowed(input logic [11:0] a,
                                      input logic [7:0]  d,
                                      input logic        halt,
                                      input logic        prot);
    logic in_flash;
    in_flash = (a >= FLASH_LO) && (a <= FLASH_HI);
    return halt && (!prot || (in_flash && (a != FLASH_CTL_ADDR || d == MASS_ERASE)));
  endfunction

  logic [11:0] addr_q;

  assign debugger_control_reg  = ctl;
  assign halt_mode_bit         = ctl[debug_cmd_pkg::HALT_BIT];
  assign debug_serial_line_out = 1'b0;
  assign debug_serial_line_oe  = drive_low;
  assign reg_addr              = addr_q;
  assign argv                  = {args, rx_data};

  assign open_ok = halt_mode_bit && !readout_protect_option;

  // Line synchroniser
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end else begin
      line_meta <= debug_serial_line_in;
      line_sync <= line_meta;
    end
  end

  debug_rx #(.CW(CNT_W)) u_rx (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .line         (line_sync),
    .mute         (tx_busy),
    .restart      (rx_restart),
    .rx_data      (rx_data),
    .rx_valid     (rx_valid),
    .rx_break     (rx_break),
    .rx_frame_err (rx_frame_err),
    .bit_len      (bit_len)
  );

  debug_tx #(.CW(CNT_W)) u_tx (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .line         (line_sync),
    .bit_len      (bit_len),
    .tx_start     (tx_start),
    .tx_byte      (tx_byte),
    .brk_start    (brk_start),
    .drive_low    (drive_low),
    .tx_busy      (tx_busy),
    .tx_done      (tx_done),
    .tx_collision (tx_collision)
  );

  // Response byte selection
  always_comb begin
    case (cmd)
      debug_cmd_pkg::CMD_REV: begin
        resp_byte = (left == debug_cmd_pkg::TWO_BYTES) ? REVISION[15:8] : REVISION[7:0];
      end
      debug_cmd_pkg::CMD_STAT: resp_byte = debugger_status_reg;
      debug_cmd_pkg::CMD_CTL_RD: resp_byte = ctl;
      debug_cmd_pkg::CMD_PC_RD: begin
        if (!open_ok) begin
          resp_byte = debug_cmd_pkg::FILL_BYTE;
        end else if (left == debug_cmd_pkg::TWO_BYTES) begin
          resp_byte = program_counter[15:8];
        end else begin
          resp_byte = program_counter[7:0];
        end
      end
      debug_cmd_pkg::CMD_REG_RD: begin
        resp_byte = open_ok ? reg_rdata : debug_cmd_pkg::FILL_BYTE;
      end
      default: resp_byte = debug_cmd_pkg::FILL_BYTE;
    endcase
  end

  always_comb begin
    next_state     = state;
    next_cmd       = cmd;
    next_args      = args;
    next_arg_left  = arg_left;
    next_left      = left;
    next_addr      = addr;
    next_ctl       = ctl;
    next_pc_wdata  = pc_wdata;
    next_pc_write  = 1'b0;
    next_reg_addr  = addr_q;
    next_reg_wdata = reg_wdata;
    next_reg_write = 1'b0;
    next_reg_read  = 1'b0;
    tx_start       = 1'b0;
    tx_byte        = resp_byte;
    brk_start      = 1'b0;
    rx_restart     = 1'b0;
    case (state)
      ST_IDLE: begin
        if (rx_valid) begin
          next_cmd  = rx_data;
          next_args = '0;
          // every command code decoded in all modes; other codes return to idle
          case (rx_data)
            debug_cmd_pkg::CMD_REV,
            debug_cmd_pkg::CMD_PC_RD: begin
              next_left  = debug_cmd_pkg::TWO_BYTES;
              next_state = ST_LOAD;
            end
            debug_cmd_pkg::CMD_STAT,
            debug_cmd_pkg::CMD_CTL_RD: begin
              next_left  = debug_cmd_pkg::ONE_BYTE;
              next_state = ST_LOAD;
            end
            debug_cmd_pkg::CMD_CTL_WR: begin
              next_arg_left = debug_cmd_pkg::ARGS_CTL;
              next_state    = ST_ARG;
            end
            debug_cmd_pkg::CMD_PC_WR: begin
              next_arg_left = debug_cmd_pkg::ARGS_PC;
              next_state    = ST_ARG;
            end
            debug_cmd_pkg::CMD_REG_WR,
            debug_cmd_pkg::CMD_REG_RD: begin
              next_arg_left = debug_cmd_pkg::ARGS_REG;
              next_state    = ST_ARG;
            end
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_ARG: begin
        if (rx_valid) begin
          next_args     = argv[15:0];
          next_arg_left = arg_left - 2'h1;
          if (arg_left == 2'h1) begin
            next_state = ST_IDLE;
            case (cmd)
              debug_cmd_pkg::CMD_CTL_WR: begin
                next_ctl = ctl_write(ctl, rx_data, readout_protect_option);
              end
              debug_cmd_pkg::CMD_PC_WR: begin
                next_pc_wdata = argv[15:0];
                next_pc_write = open_ok;
              end
              default: begin
                next_addr  = {argv[19:16], argv[15:8]};
                next_left  = (argv[7:0] == 8'h00) ? debug_cmd_pkg::BLOCK_MAX
                                                  : {1'b0, argv[7:0]};
                next_state = (cmd == debug_cmd_pkg::CMD_REG_WR) ? ST_WDATA : ST_FETCH;
              end
            endcase
          end
        end
      end
      ST_WDATA: begin
        if (rx_valid) begin
          if (wr_allowed(addr, rx_data, halt_mode_bit, readout_protect_option)) begin
            next_reg_write = 1'b1;
            next_reg_addr  = addr;
            next_reg_wdata = rx_data;
          end
          next_addr = addr + 12'h001;
          next_left = left - 9'h001;
          if (left == debug_cmd_pkg::ONE_BYTE) next_state = ST_IDLE;
        end
      end
      ST_FETCH: begin
        next_reg_addr = addr;
        next_reg_read = open_ok;
        next_state    = ST_WAIT;
      end
      ST_WAIT: next_state = ST_LOAD;
      ST_LOAD: begin
        tx_start   = 1'b1;
        next_state = ST_SEND;
      end
      ST_SEND: begin
        if (tx_done) begin
          next_left = left - 9'h001;
          next_addr = addr + 12'h001;
          if (left == debug_cmd_pkg::ONE_BYTE) begin
            next_state = ST_IDLE;
          end else if (cmd == debug_cmd_pkg::CMD_REG_RD) begin
            next_state = ST_FETCH;
          end else begin
            next_state = ST_LOAD;
          end
        end
      end
      ST_BREAK: begin
        if (tx_done) begin
          rx_restart = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (state != ST_BREAK && (rx_break || rx_frame_err || tx_collision)) begin
      next_state     = ST_BREAK;
      brk_start      = 1'b1;
      tx_start       = 1'b0;
      next_pc_write  = 1'b0;
      next_reg_write = 1'b0;
      next_reg_read  = 1'b0;
    end
    if (halt_request) next_ctl[debug_cmd_pkg::HALT_BIT] = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      cmd       <= '0;
      args      <= '0;
      arg_left  <= '0;
      left      <= '0;
      addr      <= '0;
      addr_q    <= '0;
      ctl       <= debug_cmd_pkg::CTL_RESET;
      pc_wdata  <= '0;
      pc_write  <= 1'b0;
      reg_wdata <= '0;
      reg_write <= 1'b0;
      reg_read  <= 1'b0;
    end else begin
      state     <= next_state;
      cmd       <= next_cmd;
      args      <= next_args;
      arg_left  <= next_arg_left;
      left      <= next_left;
      addr      <= next_addr;
      addr_q    <= next_reg_addr;
      ctl       <= next_ctl;
      pc_wdata  <= next_pc_wdata;
      pc_write  <= next_pc_write;
      reg_wdata <= next_reg_wdata;
      reg_write <= next_reg_write;
      reg_read  <= next_reg_read;
    end
  end
endmodule // debug_port_command_decoder
`default_nettype wire

/* testbench/dbg_cmd_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dbg_cmd_sva #(
  parameter logic [11:0] FLASH_LO       = 12'hff8,
  parameter logic [11:0] FLASH_HI       = 12'hfff,
  parameter logic [11:0] FLASH_CTL_ADDR = 12'hff8,
  parameter logic [7:0]  MASS_ERASE     = 8'h94
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Watched ports
  input wire logic        readout_protect_option,
  input wire logic [7:0]  debugger_control_reg,
  input wire logic        halt_mode_bit,
  input wire logic        pc_write,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_halt_mirror: assert property (halt_mode_bit == debugger_control_reg[7])
    else $error("halt bit differs from control bit");
  a_fixed_bits: assert property (debugger_control_reg[4:1] == 4'h0)
    else $error("control bits 4 to 1 not zero");
  a_halt_kept: assert property (readout_protect_option && halt_mode_bit |=> halt_mode_bit)
    else $error("halt bit cleared under protection");
  a_pc_gated: assert property (pc_write |-> halt_mode_bit && !readout_protect_option)
    else $error("program counter written while barred");
  a_read_gated: assert property (reg_read |-> halt_mode_bit && !readout_protect_option)
    else $error("register read while barred");
  a_write_halt: assert property (reg_write |-> halt_mode_bit)
    else $error("register write outside halt");
  a_write_flash: assert property (reg_write && readout_protect_option
    |-> reg_addr >= FLASH_LO && reg_addr <= FLASH_HI)
    else $error("protected write outside flash block");
  a_erase_only: assert property (reg_write && readout_protect_option
    && reg_addr == FLASH_CTL_ADDR |-> reg_wdata == MASS_ERASE)
    else $error("protected flash control write not erase");
  a_read_gap: assert property (reg_read |=> !reg_read [*2])
    else $error("register reads too close");
endmodule // dbg_cmd_sva
bind debug_port_command_decoder dbg_cmd_sva #(.FLASH_LO(FLASH_LO), .FLASH_HI(FLASH_HI),
  .FLASH_CTL_ADDR(FLASH_CTL_ADDR), .MASS_ERASE(MASS_ERASE)) u_sva (.clk_sys(clk_sys),
  .rst(rst), .readout_protect_option(readout_protect_option),
  .debugger_control_reg(debugger_control_reg), .halt_mode_bit(halt_mode_bit),
  .pc_write(pc_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read));
`default_nettype wire

/* testbench/dbg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dbg_host #(
  parameter int T = 24
) (
  // Clock
  input wire logic clk_sys,
  // Line
  input wire logic dev_oe,
  output logic     line
);
  logic       pull = 1'b0;
  logic [7:0] b;
  logic [7:0] rxq[$];
  // Pull-up holds the line high unless a party pulls
  assign line = !(pull | dev_oe);
  // start, eight bits LSB first, stop
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      pull <= !f[i];
      repeat (T) @(posedge clk_sys);
    end
  endtask
  initial forever begin
    @(posedge clk_sys iff (!line && !pull));
    repeat (T / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (T) @(posedge clk_sys);
      b[i] = line;
    end
    // Hand over only once the stop bit has ended
    repeat (T + T / 2) @(posedge clk_sys);
    rxq.push_back(b);
  end
endmodule // dbg_host
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] REV = 16'h0101;
  logic        clk_sys, rst, prot, oe, line, halt, pc_write, reg_write, reg_read;
  logic [7:0]  ctl, reg_wdata, reg_rdata, got;
  logic [11:0] reg_addr;
  logic [15:0] pc_wdata;
  logic [7:0]  mem [4096];
  int          failures, tests_run, pcw_n, cycles = 0;
  dbg_host host (.clk_sys(clk_sys), .dev_oe(oe), .line(line));
  debug_port_command_decoder #(.REVISION(REV)) uut (.clk_sys(clk_sys), .rst(rst),
    .debug_serial_line_in(line), .debug_serial_line_out(), .debug_serial_line_oe(oe),
    .readout_protect_option(prot), .debugger_status_reg(8'h3c), .halt_request(1'b0),
    .debugger_control_reg(ctl), .halt_mode_bit(halt), .program_counter(16'hbeef),
    .pc_wdata(pc_wdata), .pc_write(pc_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Register file, write counter and timeout
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (reg_write) mem[reg_addr] <= reg_wdata;
    if (reg_read) reg_rdata <= mem[reg_addr];
    if (pc_write) pcw_n <= pcw_n + 1;
    if (cycles == 98000) begin
      failures++;
      complete_run();
    end
  end
  function automatic logic [15:0] iv(input int a);
    return {8'h00, a[7:0] ^ 8'h5a};
  endfunction
  function automatic logic [15:0] m(input int a);
    return {8'h00, mem[a]};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tx(input logic [7:0] q[$]);
    foreach (q[i]) host.send(q[i]);
  endtask
  task automatic rx(input logic [15:0] e);
    for (int n = 0; n < 2000 && host.rxq.size() == 0; n++) @(posedge clk_sys);
    got = (host.rxq.size() != 0) ? host.rxq.pop_front() : 8'hxx;
    chk({8'h00, got}, e);
  endtask
  task automatic t_normal();
    tx('{8'h00});
    rx({8'h00, REV[15:8]});
    rx({8'h00, REV[7:0]});
    tx('{8'h02});
    rx(16'h003c);
    tx('{8'h07});
    rx(16'h00ff);
    rx(16'h00ff);
    tx('{8'h06, 8'h12, 8'h34, 8'h09, 8'h00, 8'h10, 8'h01});
    rx(16'h00ff);
    tx('{8'h08, 8'h00, 8'h10, 8'h01, 8'h77});
    chk(m(16), iv(16));
    tx('{8'h01, 8'h05});
    rx(16'h0000);
    chk(16'(host.rxq.size()), 16'h0000);
    chk(pcw_n[15:0], 16'h0000);
  endtask
  task automatic t_halt();
    tx('{8'h04, 8'hff, 8'h05});
    rx(16'h00e1);
    tx('{8'h06, 8'h12, 8'h34});
    chk(pc_wdata, 16'h1234);
    chk(pcw_n[15:0], 16'h0001);
    tx('{8'h07});
    rx(16'h00be);
    rx(16'h00ef);
    tx('{8'h09, 8'h00, 8'h10, 8'h03});
    for (int i = 0; i < 3; i++) rx(iv(16 + i));
    tx('{8'h08, 8'h01, 8'h00, 8'h00});
    for (int i = 0; i < 256; i++) host.send(i[7:0]);
    chk(m(12'h100), 16'h0000);
    chk(m(12'h1ff), 16'h00ff);
    chk(m(12'h200), iv(12'h200));
  endtask
  task automatic t_prot();
    prot <= 1'b1;
    tx('{8'h04, 8'h00, 8'h05});
    rx(16'h0080);
    tx('{8'h07});
    rx(16'h00ff);
    rx(16'h00ff);
    tx('{8'h09, 8'h00, 8'h10, 8'h01});
    rx(16'h00ff);
    tx('{8'h08, 8'h0f, 8'hf7, 8'h02, 8'haa, 8'h94, 8'h08, 8'h0f, 8'hf8, 8'h01, 8'h33});
    chk(m(12'hff7), iv(12'hff7));
    chk(m(12'hff8), 16'h0094);
    tx('{8'h06, 8'h00, 8'h00});
    chk(pcw_n[15:0], 16'h0001);
  endtask
  task automatic t_break();
    int n;
    n = 0;
    host.pull <= 1'b1;
    @(negedge clk_sys iff oe);
    while (oe) begin
      n++;
      @(negedge clk_sys);
    end
    chk(16'(n), 16'h1000);
    @(posedge clk_sys);
    host.pull <= 1'b0;
    repeat (24) @(posedge clk_sys);
    host.send(8'h80);
    tx('{8'h05});
    rx(16'h0080);
  endtask
  task automatic complete_run();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    prot = 1'b0;
    failures = 0;
    tests_run = 0;
    pcw_n = 0;
    reg_rdata = 8'h00;
    for (int i = 0; i < 4096; i++) mem[i] = 8'(iv(i));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    host.send(8'h80);
    t_normal();
    t_halt();
    t_prot();
    t_break();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
